/* core/tsm_monitor.sv */
// Temperature readout, limit monitor, alarm pin and serial slave
`timescale 1ns/1ps
`default_nettype none
`include "tsm_params.svh"
module tsm_monitor #(
  parameter int unsigned CONV_CYC = `TSM_CONV_CYC,
  parameter int unsigned PU_CYC = `TSM_PU_CYC,
  parameter int unsigned TMO_CYC = `TSM_TMO_CYC
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Sensor core sample
  input wire logic [`TSM_TW-1:0] thermal_sensor_core_in,
  // Register port
  input wire logic [`TSM_AW-1:0] reg_addr_in,
  input wire logic [`TSM_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`TSM_DW-1:0] reg_rdata_out,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_select_bit0_in,
  input wire logic addr_select_bit1_in,
  input wire logic addr_select_bit2_in,
  // Alarm pin and interrupt
  output logic alarm_out,
  output logic alarm_oe_out,
  output logic irq_out
);
  localparam int TW = $clog2(TMO_CYC + 1);

  // Signed greater-than on temperature codes
  function automatic logic temp_gt(input logic [`TSM_TW-1:0] a, input logic [`TSM_TW-1:0] b);
    temp_gt = $signed(a) > $signed(b);
  endfunction

  // ****************************************
  // Registers and conversion
  // ****************************************
  logic [`TSM_DW-1:0] cfg, high_lim, low_lim, crit_lim, temperature_result_reg;
  logic [`TSM_IRQ_W-1:0] irq_stat, irq_en;
  logic result_valid, alarm_latch, cond_q;
  logic conv_tick, pu_done;

  tsm_conv_timer #(.CONV_CYC(CONV_CYC), .PU_CYC(PU_CYC)) u_timer (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .clk_en_in(clk_en_in),
    .run_in(!cfg[`TSM_CFG_SHDN]),
    .tick_out(conv_tick),
    .pu_done_out(pu_done)
  );

  // Decode and comparison
  wire wr_cfg = reg_wr_in && (reg_addr_in == `TSM_REG_CFG);
  wire wr_high = reg_wr_in && (reg_addr_in == `TSM_REG_HIGH);
  wire wr_low = reg_wr_in && (reg_addr_in == `TSM_REG_LOW);
  wire wr_crit = reg_wr_in && (reg_addr_in == `TSM_REG_CRIT);
  wire wr_clr = reg_wr_in && (reg_addr_in == `TSM_REG_IRQ_CLR);
  wire wr_en = reg_wr_in && (reg_addr_in == `TSM_REG_IRQ_EN);
  wire store = conv_tick && pu_done;
  wire [`TSM_TW-1:0] res = temperature_result_reg[`TSM_TW-1:0];
  wire above_high = temp_gt(res, high_lim[`TSM_TW-1:0]);
  wire below_low = temp_gt(low_lim[`TSM_TW-1:0], res);
  wire above_crit = temp_gt(res, crit_lim[`TSM_TW-1:0]);
  wire alarm_cond = result_valid && (above_crit ||
                    (!cfg[`TSM_CFG_CRIT_ONLY] && (above_high || below_low)));
  wire alarm_rise = alarm_cond && !cond_q;
  wire alarm_clr = wr_cfg && reg_wdata_in[`TSM_CFG_CLR];
  wire asserted = cfg[`TSM_CFG_MODE] ? alarm_latch : alarm_cond;
  wire next_alarm_oe = cfg[`TSM_CFG_EN] && (asserted ^ cfg[`TSM_CFG_POL]);

  // Writable registers, all zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cfg <= `TSM_RESET_VAL;
      high_lim <= `TSM_RESET_VAL;
      low_lim <= `TSM_RESET_VAL;
      crit_lim <= `TSM_RESET_VAL;
      irq_en <= '0;
    end else if (clk_en_in) begin
      if (wr_cfg) cfg <= reg_wdata_in & ~(`TSM_DW'(1) << `TSM_CFG_CLR);
      if (wr_high) high_lim <= reg_wdata_in;
      if (wr_low) low_lim <= reg_wdata_in;
      if (wr_crit) crit_lim <= reg_wdata_in;
      if (wr_en) irq_en <= reg_wdata_in[`TSM_IRQ_W-1:0];
    end
  end

  // Result store, held while shut down
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      temperature_result_reg <= `TSM_RESET_VAL;
      result_valid <= 1'b0;
    end else if (clk_en_in && store) begin
      temperature_result_reg <= `TSM_DW'(thermal_sensor_core_in);
      result_valid <= 1'b1;
    end
  end

  // Alarm latch, edge memory and pin
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      cond_q <= 1'b0;
      alarm_latch <= 1'b0;
      alarm_oe_out <= 1'b0;
      alarm_out <= 1'b0;
    end else if (clk_en_in) begin
      cond_q <= alarm_cond;
      alarm_latch <= alarm_rise || (alarm_latch && !alarm_clr);
      alarm_oe_out <= next_alarm_oe;
      alarm_out <= 1'b0;
    end
  end

  // ****************************************
  // Serial slave
  // ****************************************
  logic [2:0] scl_sh, sda_sh;
  logic [1:0] as0_sh, as1_sh, as2_sh;
  tsm_pkg::tsm_i2c_state_t st;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh, tx_sh;
  logic rw, byte_lo, busy, nack;
  logic [TW-1:0] tmo_cnt;

  // Pin synchronisers, third stage for edges
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      scl_sh <= 3'h7;
      sda_sh <= 3'h7;
      as0_sh <= 2'h0;
      as1_sh <= 2'h0;
      as2_sh <= 2'h0;
    end else if (clk_en_in) begin
      scl_sh <= {scl_sh[1:0], scl_in};
      sda_sh <= {sda_sh[1:0], sda_in};
      as0_sh <= {as0_sh[0], addr_select_bit0_in};
      as1_sh <= {as1_sh[0], addr_select_bit1_in};
      as2_sh <= {as2_sh[0], addr_select_bit2_in};
    end
  end

  wire scl_s = scl_sh[1];
  wire sda_s = sda_sh[1];
  wire scl_rise = scl_s && !scl_sh[2];
  wire scl_fall = !scl_s && scl_sh[2];
  wire start_c = scl_s && scl_sh[2] && !sda_s && sda_sh[2];
  wire stop_c = scl_s && scl_sh[2] && sda_s && !sda_sh[2];
  wire [6:0] my_addr = {`TSM_PREAMBLE, as2_sh[1], as1_sh[1], as0_sh[1]};
  wire addr_hit = (rx_sh[7:1] == my_addr);
  wire byte_end = (bit_cnt == `TSM_BYTE_BITS);
  wire tmo_hit = busy && !scl_s && (tmo_cnt == TW'(TMO_CYC - 1));
  wire [7:0] tx_byte = byte_lo ? temperature_result_reg[7:0] : temperature_result_reg[15:8];

  // Timeout counter between START and STOP
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      tmo_cnt <= '0;
    end else if (clk_en_in) begin
      tmo_cnt <= (!busy || scl_fall || tmo_hit) ? '0 : tmo_cnt + 1'b1;
    end
  end

  // Slave sequencer
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= tsm_pkg::st_idle;
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      rw <= 1'b0;
      byte_lo <= 1'b0;
      nack <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else if (clk_en_in) begin
      sda_out <= 1'b0;
      if (tmo_hit || stop_c) begin
        st <= tsm_pkg::st_idle;
        busy <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (start_c) begin
        st <= tsm_pkg::st_addr;
        busy <= 1'b1;
        bit_cnt <= 4'h0;
        byte_lo <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (st == tsm_pkg::st_addr || st == tsm_pkg::st_rx) begin
          rx_sh <= {rx_sh[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        if (st == tsm_pkg::st_tx) bit_cnt <= bit_cnt + 4'h1;
        if (st == tsm_pkg::st_mack) nack <= sda_s;
      end else if (scl_fall) begin
        unique case (st)
          tsm_pkg::st_idle: begin
          end
          tsm_pkg::st_addr: begin
            if (byte_end) begin
              st <= addr_hit ? tsm_pkg::st_ack : tsm_pkg::st_idle;
              rw <= rx_sh[0];
              sda_oe_out <= addr_hit;
            end
          end
          tsm_pkg::st_ack: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              st <= tsm_pkg::st_tx;
              tx_sh <= tx_byte;
              sda_oe_out <= !tx_byte[7];
              byte_lo <= !byte_lo;
            end else begin
              st <= tsm_pkg::st_rx;
              sda_oe_out <= 1'b0;
            end
          end
          tsm_pkg::st_tx: begin
            if (byte_end) begin
              st <= tsm_pkg::st_mack;
              sda_oe_out <= 1'b0;
            end else begin
              sda_oe_out <= !tx_sh[6];
              tx_sh <= {tx_sh[6:0], 1'b0};
            end
          end
          tsm_pkg::st_mack: begin
            bit_cnt <= 4'h0;
            if (nack) begin
              st <= tsm_pkg::st_idle;
            end else begin
              st <= tsm_pkg::st_tx;
              tx_sh <= tx_byte;
              sda_oe_out <= !tx_byte[7];
              byte_lo <= !byte_lo;
            end
          end
          tsm_pkg::st_rx: begin
            if (byte_end) begin
              st <= tsm_pkg::st_ack;
              sda_oe_out <= 1'b1;
            end
          end
          default: st <= tsm_pkg::st_idle;
        endcase
      end
    end
  end

  // ****************************************
  // Interrupts and read port
  // ****************************************
  wire [`TSM_IRQ_W-1:0] irq_set = {tmo_hit, alarm_rise, store};
  wire [`TSM_DW-1:0] state_word = `TSM_DW'({above_crit, below_low, above_high, busy,
                                            alarm_latch, alarm_cond, result_valid});
  wire [`TSM_DW-1:0] rd_mux =
    (reg_addr_in == `TSM_REG_CFG) ? cfg :
    (reg_addr_in == `TSM_REG_HIGH) ? high_lim :
    (reg_addr_in == `TSM_REG_LOW) ? low_lim :
    (reg_addr_in == `TSM_REG_CRIT) ? crit_lim :
    (reg_addr_in == `TSM_REG_RESULT) ? temperature_result_reg :
    (reg_addr_in == `TSM_REG_STATE) ? state_word :
    (reg_addr_in == `TSM_REG_IRQ_STAT) ? `TSM_DW'(irq_stat) :
    (reg_addr_in == `TSM_REG_IRQ_EN) ? `TSM_DW'(irq_en) : `TSM_RESET_VAL;

  // Sticky status, set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      irq_stat <= '0;
      irq_out <= 1'b0;
      reg_rdata_out <= `TSM_RESET_VAL;
    end else if (clk_en_in) begin
      irq_stat <= irq_set | (irq_stat & ~(wr_clr ? reg_wdata_in[`TSM_IRQ_W-1:0] : '0));
      irq_out <= |(irq_stat & irq_en);
      reg_rdata_out <= reg_rd_in ? rd_mux : `TSM_RESET_VAL;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in || !clk_en_in);

  sequence s_addr_done;
    st == tsm_pkg::st_addr && scl_fall && byte_end;
  endsequence
  property p_result_store;
    store |=> temperature_result_reg == `TSM_DW'($past(thermal_sensor_core_in)) ##1 result_valid;
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored");
  property p_no_early_valid;
    !pu_done |-> !result_valid;
  endproperty
  a_no_early_valid: assert property (p_no_early_valid) else $error("valid before delay");
  property p_alarm_pin;
    ##1 alarm_oe_out == ($past(cfg[`TSM_CFG_EN]) &&
        ($past(asserted) ^ $past(cfg[`TSM_CFG_POL])));
  endproperty
  a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin wrong");
  property p_comparator;
    !cfg[`TSM_CFG_MODE] && cfg[`TSM_CFG_EN] && !cfg[`TSM_CFG_POL] && alarm_cond
      && !wr_cfg |=> alarm_oe_out;
  endproperty
  a_comparator: assert property (p_comparator) else $error("comparator alarm missed");
  property p_timeout;
    tmo_hit |=> !sda_oe_out && !busy && st == tsm_pkg::st_idle;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not reset slave");
  property p_tmo_restart;
    scl_fall |=> tmo_cnt == '0;
  endproperty
  a_tmo_restart: assert property (p_tmo_restart) else $error("timeout not restarted");
  property p_addr_ack;
    s_addr_done and addr_hit and !start_c and !stop_c and !tmo_hit |=>
      sda_oe_out && st == tsm_pkg::st_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_reset_zero;
    $rose(rstn_in) |-> cfg == `TSM_RESET_VAL && !alarm_oe_out && high_lim == `TSM_RESET_VAL;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero");
  property p_read_keeps;
    reg_rd_in && !store |=> $stable(temperature_result_reg);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read disturbed result");
endmodule // tsm_monitor
`default_nettype wire

/* core/tsm_params.svh */
// Constants of the temperature limit monitor
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH
// ****************************************
// Timing
// ****************************************
`define TSM_CLK_KHZ 50000
`define TSM_CONV_PERIOD_MS 100
`define TSM_TIMEOUT_MS 25
`define TSM_POWERUP_MS 100
`define TSM_CONV_CYC (`TSM_CONV_PERIOD_MS * `TSM_CLK_KHZ)
`define TSM_TMO_CYC (`TSM_TIMEOUT_MS * `TSM_CLK_KHZ)
`define TSM_PU_CYC (`TSM_POWERUP_MS * `TSM_CLK_KHZ)
// ****************************************
// Register map and fields
// ****************************************
`define TSM_AW 4
`define TSM_DW 16
`define TSM_TW 13
`define TSM_REG_CFG 4'h0
`define TSM_REG_HIGH 4'h1
`define TSM_REG_LOW 4'h2
`define TSM_REG_CRIT 4'h3
`define TSM_REG_RESULT 4'h4
`define TSM_REG_STATE 4'h5
`define TSM_REG_IRQ_STAT 4'h6
`define TSM_REG_IRQ_CLR 4'h7
`define TSM_REG_IRQ_EN 4'h8
`define TSM_RESET_VAL 16'h0000
`define TSM_CFG_MODE 0
`define TSM_CFG_POL 1
`define TSM_CFG_EN 2
`define TSM_CFG_CLR 3
`define TSM_CFG_CRIT_ONLY 4
`define TSM_CFG_SHDN 8
`define TSM_IRQ_CONV 0
`define TSM_IRQ_ALARM 1
`define TSM_IRQ_TMO 2
`define TSM_IRQ_W 3
`define TSM_PREAMBLE 4'h3
`define TSM_BYTE_BITS 4'h8
`endif

/* core/tsm_pkg.sv */
// Types of the temperature limit monitor
package tsm_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_ack = 3'b010,
    st_tx = 3'b011,
    st_mack = 3'b100,
    st_rx = 3'b101
  } tsm_i2c_state_t;
endpackage

/* core/tsm_conv_timer.sv */
// Conversion period and power-up delay timer
`timescale 1ns/1ps
`default_nettype none
`include "tsm_params.svh"
module tsm_conv_timer #(
  parameter int unsigned CONV_CYC = `TSM_CONV_CYC,
  parameter int unsigned PU_CYC = `TSM_PU_CYC
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Control
  input wire logic run_in,
  // Status
  output logic tick_out,
  output logic pu_done_out
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int PW = $clog2(PU_CYC + 1);
  logic [CW-1:0] conv_cnt;
  logic [PW-1:0] pu_cnt;
  wire conv_end = (conv_cnt == CW'(CONV_CYC - 1));
  wire pu_end = (pu_cnt == PW'(PU_CYC - 1));

  // Period counter, one tick per conversion
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      conv_cnt <= '0;
      tick_out <= 1'b0;
    end else if (clk_en_in) begin
      tick_out <= run_in && conv_end;
      conv_cnt <= (!run_in || conv_end) ? '0 : conv_cnt + 1'b1;
    end
  end

  // Power-up delay before results count as valid
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pu_cnt <= '0;
      pu_done_out <= 1'b0;
    end else if (clk_en_in && !pu_done_out) begin
      pu_cnt <= pu_cnt + 1'b1;
      pu_done_out <= pu_end;
    end
  end

  property p_conv_period;
    @(posedge sys_clk_in) disable iff (!rstn_in)
    run_in |-> conv_cnt < CW'(CONV_CYC);
  endproperty
  a_conv_period: assert property (p_conv_period) else $error("conversion period overrun");
endmodule // tsm_conv_timer
`default_nettype wire

/* tb/tsm_host_model.sv */
// Two-wire bus master model facing the sensor's serial slave
`timescale 1ns/1ps
`default_nettype none
module tsm_host_model #(
  parameter int PH = 160
) (
  // Bus wires
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // Idle bus: clock high, data released
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // Start, also a repeated start from a low clock
  task automatic start();
    sda_oe_out = 1'b0;
    #(PH/2) scl_out = 1'b1;
    #PH sda_oe_out = 1'b1;
    #PH scl_out = 1'b0;
  endtask
  // One clock: data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #(PH/2) sda_oe_out = ~b;
    #(PH/2) scl_out = 1'b1;
    #(PH/2) r = sda_in;
    #(PH/2) scl_out = 1'b0;
  endtask
  // Eight data clocks, most significant first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
      output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(b9, r9);
  endtask
  // Stop: data rises while the clock is high, clock then stands still
  task automatic stop();
    #(PH/2) sda_oe_out = 1'b1;
    #(PH/2) scl_out = 1'b1;
    #PH sda_oe_out = 1'b0;
    #PH;
  endtask
endmodule // tsm_host_model
`default_nettype wire

/* tb/test_temp_sensor_limit_monitor.sv */
// Self-checking bench of the temperature limit monitor
`timescale 1ns/1ps
`default_nettype none
`include "tsm_params.svh"
module test_temp_sensor_limit_monitor;
  localparam int CONV = 200;
  localparam int PU = 500;
  localparam int TMO = 400;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic clk, rstn, clk_en, wr, rd, scl, host_oe, sda_o, sda_oe, al_o, al_oe, irq, r9;
  logic [2:0] pins;
  logic [12:0] sensor;
  logic [`TSM_AW-1:0] addr;
  logic [`TSM_DW-1:0] wdata, rdata, rv, ex;
  logic [15:0] mdl [16];
  logic [15:0] cfgs [3] = '{16'h0004, 16'h0006, 16'h0014};
  logic [12:0] temps [4] = '{13'h0300, 13'h0080, 13'h0180, 13'h0500};
  logic [7:0] rx;
  logic [31:0] lfsr = 32'h7141;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int rel, n;
  wire sda = ~(host_oe | sda_oe);
  // Design with short counts and the far-side master
  tsm_monitor #(.CONV_CYC(CONV), .PU_CYC(PU), .TMO_CYC(TMO)) dut (
    .sys_clk_in(clk), .rstn_in(rstn), .clk_en_in(clk_en),
    .thermal_sensor_core_in(sensor), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_select_bit0_in(pins[0]),
    .addr_select_bit1_in(pins[1]), .addr_select_bit2_in(pins[2]),
    .alarm_out(al_o), .alarm_oe_out(al_oe), .irq_out(irq));
  tsm_host_model #(.PH(80)) u_host (.sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [12:0] rt();
    return 13'(rnd() & 32'h07ff) | 13'h0800;
  endfunction
  // Expected status from the stored limits
  function automatic logic [15:0] st_exp(input logic [12:0] s, input logic co);
    logic ah, bl, ac;
    ah = $signed(s) > $signed(mdl[1][12:0]);
    bl = $signed(s) < $signed(mdl[2][12:0]);
    ac = $signed(s) > $signed(mdl[3][12:0]);
    return {9'h0, ac, bl, ah, 2'b00, ac | (~co & (ah | bl)), 1'b1};
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a < 4'h4 || a == 4'h8) mdl[a] = (a == 4'h0) ? (d & 16'hfff7) : d;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
    rreg(a);
    chk($sformatf("register %0d", a), exp & m, rv & m);
  endtask
  // New sensor value, then poll the result under a bound
  task automatic wait_res(input logic [12:0] s);
    @(posedge clk);
    sensor <= s;
    mdl[4] = {3'b000, s};
    n = 0;
    do begin
      rreg(4'h4);
      n += 2;
    end while (rv !== mdl[4] && n < PU + 2 * CONV);
    chk("result", mdl[4], rv);
  endtask
  // Clock and run limit
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    sensor = 13'h0123;
    pins = 3'(rnd());
    foreach (mdl[i]) mdl[i] = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rel = cyc;
    for (int i = 0; i < 16; i++) rchk(4'(i), 16'h0000, 16'hffff);
    chk("pins", 16'h0, {11'h0, sda_o, sda_oe, al_o, al_oe, irq});
    $display("reset test done");
    for (int i = 1; i < 10; i++) wreg(4'(i), (i == 8) ? 16'(rnd() & 7) : 16'(rnd() & 32'hfff));
    wreg(4'h0, 16'h001f);
    // Status word compares the limits even before a result is valid
    for (int i = 0; i < 16; i++) begin
      ex = (i == 5) ? (st_exp(13'h0, mdl[0][4]) & 16'h0070) : mdl[i];
      rchk(4'(i), ex, 16'hffff);
    end
    wreg(4'h0, 16'h0000);
    wreg(4'h8, 16'h0000);
    // Write with the clock enable low must not land
    @(posedge clk);
    clk_en <= 1'b0;
    addr <= 4'h1;
    wdata <= ~mdl[1];
    wr <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b1;
    wr <= 1'b0;
    rchk(4'h1, mdl[1], 16'hffff);
    $display("register test done");
    wait_res(rt());
    chk("powerup", 16'h1, 16'(cyc - rel >= PU));
    rchk(4'h5, 16'h0001, 16'h0001);
    wreg(4'h7, 16'h0007);
    rchk(4'h6, 16'h0000, 16'h0001);
    wreg(4'h8, 16'h0001);
    idle(2);
    chk("irq", 16'h0, {15'h0, irq});
    wait_res(rt());
    chk("period", 16'h1, 16'(n <= CONV + 6));
    idle(2);
    chk("irq", 16'h1, {15'h0, irq});
    wreg(4'h8, 16'h0000);
    idle(2);
    chk("irq", 16'h0, {15'h0, irq});
    rchk(4'h6, 16'h0001, 16'h0001);
    $display("conversion test done");
    wreg(4'h1, 16'h0200);
    wreg(4'h2, 16'h0100);
    wreg(4'h3, 16'h0400);
    foreach (cfgs[c]) begin
      wreg(4'h0, cfgs[c]);
      foreach (temps[t]) begin
        wait_res(temps[t]);
        ex = st_exp(temps[t], cfgs[c][4]);
        rchk(4'h5, ex, 16'h0073);
        idle(3);
        chk("alarm", {15'h0, cfgs[c][2] & (ex[1] ^ cfgs[c][1])}, {15'h0, al_oe});
      end
    end
    $display("comparator test done");
    wreg(4'h0, 16'h0005);
    wait_res(13'h0180);
    wreg(4'h0, 16'h000d);
    wreg(4'h7, 16'h0007);
    idle(3);
    chk("alarm", 16'h0, {15'h0, al_oe});
    wait_res(13'h0300);
    idle(3);
    chk("alarm", 16'h1, {15'h0, al_oe});
    rchk(4'h6, 16'h0003, 16'h0003);
    wait_res(13'h0180);
    idle(3);
    chk("alarm", 16'h1, {15'h0, al_oe});
    wreg(4'h0, 16'h000d);
    idle(3);
    chk("alarm", 16'h0, {15'h0, al_oe});
    $display("latch test done");
    wreg(4'h0, 16'h0100);
    sensor <= 13'h0aaa;
    idle(2 * CONV);
    rchk(4'h4, mdl[4], 16'hffff);
    $display("shutdown test done");
    wreg(4'h7, 16'h0007);
    idle(1);
    u_host.start();
    u_host.xfer({4'h3, pins, 1'b1}, 1'b1, rx, r9);
    chk("ack", 16'h0, {15'h0, r9});
    idle(TMO - 100);
    chk("sda", 16'h1, {15'h0, sda_oe});
    rchk(4'h5, 16'h0008, 16'h0008);
    u_host.bit_io(1'b1, r9);
    idle(TMO - 100);
    chk("sda", 16'h1, {15'h0, sda_oe});
    rchk(4'h6, 16'h0000, 16'h0004);
    idle(150);
    chk("sda", 16'h0, {15'h0, sda_oe});
    rchk(4'h6, 16'h0004, 16'h0004);
    rchk(4'h5, 16'h0000, 16'h0008);
    u_host.stop();
    $display("timeout test done");
    u_host.start();
    u_host.xfer({4'h3, pins, 1'b1}, 1'b1, rx, r9);
    chk("ack", 16'h0, {15'h0, r9});
    u_host.xfer(8'hff, 1'b0, rx, r9);
    chk("high byte", mdl[4] >> 8, {8'h0, rx});
    u_host.xfer(8'hff, 1'b1, rx, r9);
    chk("low byte", mdl[4] & 16'h00ff, {8'h0, rx});
    u_host.stop();
    // Write session: address and data byte both acknowledged
    u_host.start();
    u_host.xfer({4'h3, pins, 1'b0}, 1'b1, rx, r9);
    chk("ack", 16'h0, {15'h0, r9});
    u_host.xfer(8'h5a, 1'b1, rx, r9);
    chk("data ack", 16'h0, {15'h0, r9});
    u_host.stop();
    for (int i = 0; i < 4; i++) begin
      u_host.start();
      u_host.xfer({4'h3, pins, 1'b1} ^ (8'h02 << i), 1'b1, rx, r9);
      chk("nack", 16'h1, {15'h0, r9});
      u_host.stop();
    end
    $display("serial test done");
    conclude();
  end
endmodule // test_temp_sensor_limit_monitor
`default_nettype wire
